/* core/cfgpp_port.sv */
// Configuration host port: strobes, status, address and processor pins
//
// Operation
// - Selected only when both chip selects agree
// - In async mode, selected read strobe low turns D7 into output
// - Status high means ready, low busy
// - Selected write strobe low captures data byte
// - Write wins when both strobes asserted
// - Master parallel drives memory address outputs
// - Serial, async and slave modes float address pins with pull-ups
// - Interrupt request output is active low
// - Style A drives burst inhibit output
// - Style A acknowledge is active high
// - Style B ready is active low
// - Pins become user I/O after configuration, processor pins only when not kept in use
// - Ready output mirrors D7 status in async and slave modes; read clock in master parallel
// - Configuration bytes arrive on D[7:0]
`timescale 1ns/100ps
`include "cfgpp_params.svh"
module cfgpp_port #(
  parameter int AW       = `CFGPP_ADDR_W,
  parameter int DW       = `CFGPP_DATA_W,
  parameter int DEPTH    = `CFGPP_FIFO_DEPTH,
  parameter int MEM_CYC  = `CFGPP_MEM_ACCESS_CYC
) (
  input  wire logic          i_ref_clk,          // 125 MHz clock
  input  wire logic          i_reset_n,          // Async reset, low
  input  wire logic [2:0]    i_cfg_mode,         // Configuration mode
  input  wire logic          i_cfg_done,         // Configuration complete
  input  wire logic          i_mpi_used,         // Processor port kept
  input  wire logic          i_chip_select_low_n,// Select, active low
  input  wire logic          i_chip_select_high, // Select, active high
  input  wire logic          i_read_strobe_n,    // Read / transfer strobe
  input  wire logic          i_write_strobe_n,   // Write strobe, low
  input  wire logic          i_host_bus_clock,   // Host bus clock
  input  wire logic          i_host_read_write,  // Host direction
  input  wire logic          i_irq_req,          // Interrupt from core
  input  wire logic [DW-1:0] i_data,             // D pins input
  output logic      [DW-1:0] o_data,             // D pins output
  output logic      [DW-1:0] o_data_oe,          // D pins enable
  output logic      [AW-1:0] o_config_address,   // Address pins out
  output logic               o_config_address_oe,// Address enable
  output logic               o_addr_pullup_en,   // Address pull-ups
  output logic               o_ready_rclk,       // Ready / read clock
  output logic               o_irq_out_n,        // Interrupt, low
  output logic               o_burst_inhibit,    // Burst inhibit
  output logic               o_transfer_ack,     // Transfer ack/ready
  output logic               o_cs_user_io,       // Selects released
  output logic               o_mpi_user_io,      // Processor pins free
  output logic      [DW-1:0] o_cfg_byte,         // Byte to loader
  output logic               o_cfg_valid,        // Byte valid
  input  wire logic          i_cfg_ready         // Loader takes byte
);

  logic rst_meta_q;
  logic rst_n;

  // Release edge is synchronised; assertion stays asynchronous
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  cfgpp_pkg::cfgpp_mode_t      mode;
  cfgpp_pkg::cfgpp_bus_state_t st_q;
  logic            in_cfg;
  logic            m_async;
  logic            m_slave;
  logic            m_master;
  logic            m_proc_a;
  logic            m_proc_b;
  logic            proc_on;
  logic            selected;
  logic            wr_prev_q;
  logic            wr_fall;
  logic            rd_req;
  logic            bclk_prev_q;
  logic            bclk_rise;
  logic            host_write;
  logic            xfer_write_q;
  logic            ack_on_q;
  logic            busy_q;
  logic            ready;
  logic            per_push;
  logic            mem_push;
  logic            proc_push;
  logic            mem_take;
  logic            mem_rclk;
  logic [AW-1:0]   mem_addr;
  logic            out_load;

  cfgpp_fifo_if #(.W(DW)) fbus ();

  assign mode     = cfgpp_pkg::cfgpp_mode_t'(i_cfg_mode);
  assign in_cfg   = !i_cfg_done;
  assign m_async  = in_cfg && (mode == cfgpp_pkg::CFGPP_MODE_ASYNC_PER);
  assign m_slave  = in_cfg && (mode == cfgpp_pkg::CFGPP_MODE_SLAVE_PAR);
  assign m_master = in_cfg && (mode == cfgpp_pkg::CFGPP_MODE_MASTER_PAR);
  // Processor port survives configuration only when kept in use
  assign proc_on  = in_cfg || i_mpi_used;
  assign m_proc_a = proc_on && (mode == cfgpp_pkg::CFGPP_MODE_PROC_A);
  assign m_proc_b = proc_on && (mode == cfgpp_pkg::CFGPP_MODE_PROC_B);

  // After configuration chip selects are no longer decoded
  assign selected = in_cfg && !i_chip_select_low_n
                    && i_chip_select_high;

  assign wr_fall   = wr_prev_q && !i_write_strobe_n;
  // A write strobe masks any concurrent read
  assign rd_req    = m_async && selected && !i_read_strobe_n
                     && i_write_strobe_n;
  assign bclk_rise = i_host_bus_clock && !bclk_prev_q;
  // Style A writes with low, style B with high
  assign host_write = m_proc_a ? !i_host_read_write
                               : i_host_read_write;

  assign ready = !busy_q;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_q   <= 1'b1;
      bclk_prev_q <= 1'b0;
    end else begin
      wr_prev_q   <= i_write_strobe_n;
      bclk_prev_q <= i_host_bus_clock;
    end
  end

  // Byte sources; only one mode is live at a time
  assign per_push  = (m_async || m_slave) && selected
                     && wr_fall;
  assign mem_push  = m_master && mem_take;
  assign proc_push = (m_proc_a || m_proc_b) && (st_q == cfgpp_pkg::CFGPP_BUS_DATA)
                     && bclk_rise && xfer_write_q && fbus.wr_ready;

  assign fbus.wr_valid = per_push || mem_push || proc_push;
  assign fbus.wr_data  = i_data;

  cfgpp_fifo #(
    .W     (DW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_n),
    .bus     (fbus.fifo_mp)
  );

  cfgpp_addr_gen #(
    .AW  (AW),
    .CYC (MEM_CYC)
  ) u_addr (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_n),
    .i_run   (m_master),
    .i_space (fbus.wr_ready),
    .o_addr  (mem_addr),
    .o_rclk  (mem_rclk),
    .o_take  (mem_take)
  );

  // Output stage keeps the loader port registered
  assign out_load     = fbus.rd_valid && (!o_cfg_valid || i_cfg_ready);
  assign fbus.rd_ready = out_load;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cfg_valid <= 1'b0;
      o_cfg_byte  <= `CFGPP_DATA_RESET;
    end else if (out_load) begin
      o_cfg_valid <= 1'b1;
      o_cfg_byte  <= fbus.rd_data;
    end else if (i_cfg_ready) begin
      o_cfg_valid <= 1'b0;
    end
  end

  // Busy holds until every captured byte has left the port
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (per_push) begin
      busy_q <= 1'b1;
    end else if (!fbus.rd_valid && !(o_cfg_valid && !i_cfg_ready)) begin
      busy_q <= 1'b0;
    end
  end

  // Processor transfer sequencer, paced by the host bus clock
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= cfgpp_pkg::CFGPP_BUS_IDLE;
      xfer_write_q <= 1'b0;
      ack_on_q     <= 1'b0;
    end else if (!(m_proc_a || m_proc_b)) begin
      st_q     <= cfgpp_pkg::CFGPP_BUS_IDLE;
      ack_on_q <= 1'b0;
    end else if (bclk_rise) begin
      unique case (st_q)
        cfgpp_pkg::CFGPP_BUS_IDLE: begin
          if (!i_read_strobe_n && (selected || !in_cfg)) begin
            st_q         <= cfgpp_pkg::CFGPP_BUS_DATA;
            xfer_write_q <= host_write;
          end
        end
        cfgpp_pkg::CFGPP_BUS_DATA: begin
          // A full buffer withholds the acknowledge
          if (!xfer_write_q || fbus.wr_ready) begin
            st_q     <= cfgpp_pkg::CFGPP_BUS_ACK;
            ack_on_q <= 1'b1;
          end
        end
        cfgpp_pkg::CFGPP_BUS_ACK: begin
          st_q     <= cfgpp_pkg::CFGPP_BUS_IDLE;
          ack_on_q <= 1'b0;
        end
        default: begin
          st_q     <= cfgpp_pkg::CFGPP_BUS_IDLE;
          ack_on_q <= 1'b0;
        end
      endcase
    end
  end

  // Processor pin outputs
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_transfer_ack  <= 1'b0;
      o_burst_inhibit <= 1'b0;
      o_irq_out_n     <= 1'b1;
    end else begin
      if (m_proc_b) begin
        o_transfer_ack <= !ack_on_q;
      end else begin
        o_transfer_ack <= m_proc_a && ack_on_q;
      end
      o_burst_inhibit <= m_proc_a;
      o_irq_out_n     <= !((m_proc_a || m_proc_b) && i_irq_req);
    end
  end

  // Data pin drive: status bit or processor read byte
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_data    <= `CFGPP_DATA_RESET;
      o_data_oe <= `CFGPP_NONE_OE;
    end else if (rd_req) begin
      o_data    <= `CFGPP_DATA_RESET;
      o_data[`CFGPP_STATUS_BIT] <= ready;
      o_data_oe <= `CFGPP_STATUS_OE;
    end else if ((m_proc_a || m_proc_b) && ack_on_q && !xfer_write_q) begin
      o_data    <= `CFGPP_DATA_RESET;
      o_data[`CFGPP_STATUS_BIT] <= ready;
      o_data_oe <= `CFGPP_ALL_OE;
    end else begin
      o_data    <= `CFGPP_DATA_RESET;
      o_data_oe <= `CFGPP_NONE_OE;
    end
  end

  // Address pins: driven only for master parallel
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_config_address    <= `CFGPP_ADDR_RESET;
      o_config_address_oe <= 1'b0;
      o_addr_pullup_en    <= 1'b1;
    end else begin
      o_config_address    <= mem_addr;
      o_config_address_oe <= m_master;
      o_addr_pullup_en    <= in_cfg && !m_master
                             && !(m_proc_a || m_proc_b);
    end
  end

  // Ready pin doubles as the memory read clock
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ready_rclk  <= 1'b0;
      o_cs_user_io  <= 1'b0;
      o_mpi_user_io <= 1'b0;
    end else begin
      o_ready_rclk  <= m_master ? mem_rclk
                                : ((m_async || m_slave) && ready);
      o_cs_user_io  <= i_cfg_done;
      o_mpi_user_io <= i_cfg_done && !i_mpi_used;
    end
  end

  property p_write_captures;
    @(posedge i_ref_clk) disable iff (!rst_n)
      per_push |=> busy_q;
  endproperty
  a_write_captures: assert property (p_write_captures)
    else $error("Captured byte did not set busy");

  property p_status_d7;
    @(posedge i_ref_clk) disable iff (!rst_n)
      rd_req |=> (o_data_oe == `CFGPP_STATUS_OE)
                 && (o_data[`CFGPP_STATUS_BIT] == !$past(busy_q));
  endproperty
  a_status_d7: assert property (p_status_d7)
    else $error("D7 status not driven during read");

  property p_write_wins;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (m_async && !i_write_strobe_n && !i_read_strobe_n)
      |=> (o_data_oe == `CFGPP_NONE_OE);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("Read driven while write strobe low");

  property p_select;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (i_chip_select_low_n || !i_chip_select_high) |-> !per_push && !rd_req;
  endproperty
  a_select: assert property (p_select)
    else $error("Strobe acted while not selected");

  property p_addr_float;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (in_cfg && !m_master && !m_proc_a && !m_proc_b)
      |=> !o_config_address_oe && o_addr_pullup_en;
  endproperty
  a_addr_float: assert property (p_addr_float)
    else $error("Address pins not floated with pull-ups");

  property p_ack_a;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (m_proc_a && ack_on_q) ##1 m_proc_a |-> o_transfer_ack;
  endproperty
  a_ack_a: assert property (p_ack_a)
    else $error("Style A acknowledge not high");

  property p_ack_b;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (m_proc_b && ack_on_q) ##1 m_proc_b |-> !o_transfer_ack;
  endproperty
  a_ack_b: assert property (p_ack_b)
    else $error("Style B ready not low");

  property p_irq;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (m_proc_a && i_irq_req) |=> !o_irq_out_n;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt request not asserted low");

  property p_burst;
    @(posedge i_ref_clk) disable iff (!rst_n)
      $rose(m_proc_a) |=> o_burst_inhibit;
  endproperty
  a_burst: assert property (p_burst)
    else $error("Burst inhibit missing in style A");

  property p_ready_mirror;
    @(posedge i_ref_clk) disable iff (!rst_n)
      m_async |=> (o_ready_rclk == !$past(busy_q));
  endproperty
  a_ready_mirror: assert property (p_ready_mirror)
    else $error("Ready pin does not mirror status");

  property p_user_io;
    @(posedge i_ref_clk) disable iff (!rst_n)
      i_cfg_done |=> o_cs_user_io && !per_push;
  endproperty
  a_user_io: assert property (p_user_io)
    else $error("Chip selects not released after done");
endmodule

/* shared/cfgpp_params.svh */
// Constants for the configuration peripheral port
`ifndef CFGPP_PARAMS_SVH
`define CFGPP_PARAMS_SVH

`define CFGPP_CLK_PERIOD_NS  8
`define CFGPP_MEM_ACCESS_NS  100
`define CFGPP_MEM_ACCESS_CYC ((`CFGPP_MEM_ACCESS_NS + `CFGPP_CLK_PERIOD_NS - 1) / `CFGPP_CLK_PERIOD_NS)
`define CFGPP_ADDR_W         18
`define CFGPP_DATA_W         8
`define CFGPP_FIFO_DEPTH     16
`define CFGPP_STATUS_BIT     7
`define CFGPP_ADDR_RESET     18'h00000
`define CFGPP_STATUS_OE      8'h80
`define CFGPP_ALL_OE         8'hFF
`define CFGPP_NONE_OE        8'h00
`define CFGPP_DATA_RESET     8'h00

`endif

/* shared/cfgpp_pkg.sv */
// Types for the configuration peripheral port
package cfgpp_pkg;

  typedef enum logic [2:0] {
    CFGPP_MODE_SERIAL     = 3'h0,
    CFGPP_MODE_ASYNC_PER  = 3'h1,
    CFGPP_MODE_SLAVE_PAR  = 3'h2,
    CFGPP_MODE_MASTER_PAR = 3'h3,
    CFGPP_MODE_PROC_A     = 3'h4,
    CFGPP_MODE_PROC_B     = 3'h5
  } cfgpp_mode_t;

  typedef enum logic [1:0] {
    CFGPP_BUS_IDLE = 2'h0,
    CFGPP_BUS_DATA = 2'h1,
    CFGPP_BUS_ACK  = 2'h2
  } cfgpp_bus_state_t;

endpackage

/* shared/cfgpp_fifo_if.sv */
// Handshake bundle between the port logic and its byte FIFO
`timescale 1ns/100ps
interface cfgpp_fifo_if #(
  parameter int W = 8
);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;

  modport fifo_mp (
    input  wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data
  );
  modport user_mp (
    output wr_valid, wr_data, rd_ready,
    input  wr_ready, rd_valid, rd_data
  );
endinterface

/* core/cfgpp_fifo.sv */
// Byte FIFO with valid/ready on both sides
`timescale 1ns/100ps
module cfgpp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic    i_clk,   // System clock
  input  wire logic    i_rst_n, // Synchronised reset
  cfgpp_fifo_if.fifo_mp bus     // Fill and drain ports
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign bus.wr_ready = (cnt_q != FULL_CNT);
  assign bus.rd_valid = (cnt_q != '0);
  assign bus.rd_data  = mem[rptr_q];
  assign push = bus.wr_valid && bus.wr_ready;
  assign pop  = bus.rd_valid && bus.rd_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wptr_q] <= bus.wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      // Pointers wrap only for power-of-two depths
      if (push) wptr_q <= PW'(wptr_q + 1'b1);
      if (pop)  rptr_q <= PW'(rptr_q + 1'b1);
      cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
    end
  end

  property p_fifo_bound;
    @(posedge i_clk) disable iff (!i_rst_n)
      cnt_q <= FULL_CNT;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound)
    else $error("FIFO count over depth");

  property p_fifo_count;
    @(posedge i_clk) disable iff (!i_rst_n)
      (push && !pop) |=> (cnt_q == CW'($past(cnt_q) + 1'b1));
  endproperty
  a_fifo_count: assert property (p_fifo_count)
    else $error("FIFO count did not follow a push");
endmodule

/* core/cfgpp_addr_gen.sv */
// Master parallel address and read-clock sequencer
`timescale 1ns/100ps
`include "cfgpp_params.svh"
module cfgpp_addr_gen #(
  parameter int AW  = 18,
  parameter int CYC = 13
) (
  input  wire logic          i_clk,   // System clock
  input  wire logic          i_rst_n, // Synchronised reset
  input  wire logic          i_run,   // Fetching allowed
  input  wire logic          i_space, // Buffer can take a byte
  output logic      [AW-1:0] o_addr,  // Memory address
  output logic               o_rclk,  // Read clock to memory
  output logic               o_take   // Sample data now
);
  localparam int CNTW = $clog2(CYC + 1);
  localparam logic [CNTW-1:0] LAST = CNTW'(CYC - 1);

  logic [CNTW-1:0] cnt_q;
  logic            fire;

  assign fire = i_run && i_space && (cnt_q == LAST);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (!i_run || fire) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= CNTW'(cnt_q + 1'b1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_addr <= AW'(`CFGPP_ADDR_RESET);
      o_rclk <= 1'b0;
      o_take <= 1'b0;
    end else begin
      // Address steps only after the sample, so data matches it
      if (o_take) o_addr <= AW'(o_addr + 1'b1);
      o_rclk <= fire;
      o_take <= fire;
    end
  end

  property p_take_spacing;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_take |=> !o_take;
  endproperty
  a_take_spacing: assert property (p_take_spacing)
    else $error("Back-to-back memory samples");

  property p_addr_step;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_take |=> (o_addr == AW'($past(o_addr) + 1'b1));
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("Address did not advance after a sample");
endmodule

/* test/cfgpp_host_model.sv */
// Host processor model driving the port's strobes and data pins
`timescale 1ns/100ps
module cfgpp_host_model (
  input  wire logic       i_clk,      // Bench clock
  input  wire logic       i_ack,      // Transfer ack pin
  output logic            o_cs_low_n, // Select, low
  output logic            o_cs_high,  // Select, high
  output logic            o_rd_n,     // Read or transfer strobe
  output logic            o_wr_n,     // Write strobe
  output logic            o_bus_clk,  // Host bus clock
  output logic            o_rw,       // Direction
  output logic            o_drive,    // Data lines driven
  output logic      [7:0] o_d         // Data value
);
  logic [1:0] div_q;
  initial begin
    {o_cs_low_n, o_cs_high, o_rd_n, o_wr_n} = 4'hB;
    o_bus_clk = 1'b0;
    o_rw = 1'b1;
    o_drive = 1'b0;
    o_d = 8'h00;
    div_q = 2'h0;
  end
  // Bus clock at one eighth of the bench clock
  always @(negedge i_clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) o_bus_clk <= ~o_bus_clk;
  end
  task automatic sel(input logic lo_n, input logic hi);
    @(negedge i_clk);
    o_cs_low_n = lo_n;
    o_cs_high = hi;
  endtask
  task automatic set_rd(input logic v);
    @(negedge i_clk);
    o_rd_n = v;
  endtask
  // Strobe held two cycles, data held past its release
  task automatic write_byte(input logic [7:0] b);
    @(negedge i_clk);
    o_d = b;
    o_drive = 1'b1;
    o_wr_n = 1'b0;
    repeat (2) @(negedge i_clk);
    o_wr_n = 1'b1;
    @(negedge i_clk);
    o_drive = 1'b0;
  endtask
  // Stale acknowledge must end first, or it would pass as a new one
  task automatic xfer(input logic style_b, input logic wr, output logic ok);
    int n;
    n = 0;
    while (i_ack !== style_b && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    @(negedge o_bus_clk);
    @(negedge i_clk);
    o_rw = style_b ? wr : ~wr;
    o_d = style_b ? 8'hC3 : 8'h3C;
    o_drive = wr;
    o_rd_n = 1'b0;
    n = 0;
    while (i_ack !== ~style_b && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    ok = (n < 100);
    o_rd_n = 1'b1;
    o_drive = 1'b0;
  endtask
endmodule

/* test/cfgpp_port_tb.sv */
// Self-checking bench for the configuration host port
`timescale 1ns/100ps
module cfgpp_port_tb;
  logic clk = 1'b0;
  logic rst_n, done, used, irq;
  logic [2:0] mode;
  logic ld_rdy, cl_n, ch, rd_n, wr_n, bclk, rw, hd, ok;
  logic [7:0] hdat, d_bus, dout, doe, cbyte;
  logic [17:0] addr;
  logic aoe, pu, rdy, irq_n, bi, ack, csu, mpu, cval;
  int err_count = 0, cmp_count = 0, cyc = 0, n;
  // Released data lines float high through their pull-ups
  assign d_bus = (dout & doe) | (~doe & (hd ? hdat : 8'hFF));
  cfgpp_port dut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_cfg_mode(mode),
    .i_cfg_done(done), .i_mpi_used(used), .i_chip_select_low_n(cl_n),
    .i_chip_select_high(ch), .i_read_strobe_n(rd_n),
    .i_write_strobe_n(wr_n), .i_host_bus_clock(bclk),
    .i_host_read_write(rw), .i_irq_req(irq), .i_data(d_bus),
    .o_data(dout), .o_data_oe(doe), .o_config_address(addr),
    .o_config_address_oe(aoe), .o_addr_pullup_en(pu),
    .o_ready_rclk(rdy), .o_irq_out_n(irq_n), .o_burst_inhibit(bi),
    .o_transfer_ack(ack), .o_cs_user_io(csu), .o_mpi_user_io(mpu),
    .o_cfg_byte(cbyte), .o_cfg_valid(cval), .i_cfg_ready(ld_rdy));
  cfgpp_host_model host (
    .i_clk(clk), .i_ack(ack), .o_cs_low_n(cl_n), .o_cs_high(ch),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_bus_clk(bclk), .o_rw(rw),
    .o_drive(hd), .o_d(hdat));
  initial forever #4 clk = ~clk;
  task automatic chk(input string nm, input logic [17:0] e,
                     input logic [17:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  task automatic t_reset();
    chk("pullup", 18'h1, pu);
    chk("irq_n", 18'h1, irq_n);
    chk("data_oe", 18'h0, doe);
    chk("valid", 18'h0, cval);
    $display("t_reset finished");
  endtask
  task automatic t_async();
    host.sel(1'b1, 1'b0);
    host.write_byte(8'h11);
    chk("ready unselected", 18'h1, rdy);
    chk("valid unselected", 18'h0, cval);
    host.sel(1'b0, 1'b1);
    host.write_byte(8'hA5);
    chk("ready busy", 18'h0, rdy);
    chk("byte", 18'hA5, cbyte);
    chk("valid", 18'h1, cval);
    host.set_rd(1'b0);
    repeat (2) @(negedge clk);
    chk("status oe", 18'h80, doe);
    chk("status busy", 18'h0, d_bus[7]);
    host.write_byte(8'h5A); // Both strobes low at once
    host.set_rd(1'b1);
    ld_rdy = 1'b1;
    n = 0;
    while (!(cval === 1'b1 && cbyte === 8'h5A) && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("write wins", 18'h1, n < 20);
    n = 0;
    while (rdy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("ready again", 18'h1, n < 20);
    host.set_rd(1'b0);
    repeat (2) @(negedge clk);
    chk("status ready", 18'h1, d_bus[7]);
    host.set_rd(1'b1);
    $display("t_async finished");
  endtask
  task automatic t_slave();
    mode = 3'h2;
    host.write_byte(8'h69);
    chk("slave byte", 18'h69, cbyte);
    chk("slave busy", 18'h0, rdy);
    repeat (2) @(negedge clk);
    chk("slave ready", 18'h1, rdy);
    $display("t_slave finished");
  endtask
  task automatic t_addr();
    mode = 3'h3;
    repeat (3) @(negedge clk);
    chk("addr oe", 18'h1, aoe);
    chk("pullup master", 18'h0, pu);
    n = 0;
    while (addr === 18'h0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("first step", 18'h1, addr);
    mode = 3'h0;
    repeat (3) @(negedge clk);
    chk("addr oe serial", 18'h0, aoe);
    chk("pullup serial", 18'h1, pu);
    $display("t_addr finished");
  endtask
  task automatic t_proc(input logic sb);
    mode = sb ? 3'h5 : 3'h4;
    // A transfer left from the other style runs out first
    repeat (12) @(negedge clk);
    chk("ack idle", {17'h0, sb}, ack);
    chk("burst", {17'h0, ~sb}, bi);
    irq = 1'b1;
    repeat (3) @(negedge clk);
    chk("irq low", 18'h0, irq_n);
    irq = 1'b0;
    host.xfer(sb, 1'b1, ok);
    chk("ack write", 18'h1, ok);
    chk("proc byte", sb ? 18'hC3 : 18'h3C, cbyte);
    host.xfer(sb, 1'b0, ok);
    chk("ack read", 18'h1, ok);
    chk("read oe", 18'hFF, doe);
    chk("read status", 18'h80, dout);
    $display("t_proc finished");
  endtask
  task automatic t_done();
    done = 1'b1;
    repeat (3) @(negedge clk);
    chk("cs user", 18'h1, csu);
    chk("mpi user", 18'h1, mpu);
    used = 1'b1;
    repeat (3) @(negedge clk);
    chk("mpi kept", 18'h0, mpu);
    $display("t_done finished");
  endtask
  initial begin
    rst_n = 1'b0;
    done = 1'b0;
    used = 1'b0;
    irq = 1'b0;
    mode = 3'h1;
    ld_rdy = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_async();
    t_slave();
    t_addr();
    t_proc(1'b0);
    t_proc(1'b1);
    t_done();
    close_out();
  end
endmodule
